// [pkg/rfs_pkg.sv]
// receive filter and status package: register map, field layout, carriers, frame figures
// assumes a single 40 MHz clock and byte-wide received data from the decoder
// Function
// - save_errored_packets clear rejects CRC/alignment errored packets; set keeps them
// - accept_runts set keeps packets of 8 to 63 bytes; clear rejects under 64
// - accept_broadcast set keeps all-ones destination; clear rejects broadcast
// - accept_multicast set checks group address hash bit; clear drops multicast
// - promiscuous_physical keeps every physical address; else station address must match
// - broadcast and multicast acceptance combine as OR with own station match
// - after a good packet the status byte is written to buffer memory
// - errored packet status written only when saving errors; otherwise nothing written
// - receive_status clears as the next packet begins to arrive
// - received_intact set only when CRC, alignment, overrun, missed are all zero
// - CRC mismatch sets CRC flag, bumps CRC tally; alignment errors set it too
// - off-boundary end with failing CRC sets alignment flag, bumps alignment tally
// - unserviced FIFO overflow sets overrun flag and aborts the packet
// - unstorable packet for node sets missed flag and bumps missed tally
// - address_type_flag is 0 for physical match, 1 for group match
// - receiver_disabled_flag follows entry and exit of monitor mode
// - deferring_flag follows carrier sense or collision
// - alignment/CRC pair: 00 good, 01 CRC, 11 alignment plus CRC, never 10
// - transmit start loads DMA address high byte from page start, low byte zero
// - every register is eight bits wide; wide values split in byte registers
// - station address compared byte by byte against six address bytes
// - six CRC bits after destination address pick one of 64 hash bits
package rfs_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFS_TX_PAGE_START = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_RX_CONFIG = 4'hC;
    localparam logic [ADDR_W-1:0] OFS_RX_STATUS = 4'hC;
    localparam logic [ADDR_W-1:0] OFS_ALIGN_TALLY = 4'hD;
    localparam logic [ADDR_W-1:0] OFS_CRC_TALLY = 4'hE;
    localparam logic [ADDR_W-1:0] OFS_MISSED_TALLY = 4'hF;
    localparam logic [7:0] RST_RX_CONFIG = 8'h00;
    localparam logic [7:0] RST_TX_PAGE_START = 8'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // ************************************************************
    // frame figures
    // ************************************************************
    localparam int LEN_W = 16;
    localparam logic [LEN_W-1:0] MIN_FRAME = 16'h0040;
    localparam logic [LEN_W-1:0] MIN_RUNT = 16'h0008;
    localparam logic [LEN_W-1:0] LAST_DA_BYTE = 16'h0005;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY = 32'hEDB88320;
    localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
    localparam int TALLY_W = 8;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic [1:0] spare;
        logic monitor_only;
        logic promiscuous_physical;
        logic accept_multicast;
        logic accept_broadcast;
        logic accept_runts;
        logic save_errored_packets;
    } rfs_cfg_t;

    typedef struct packed {
        logic deferring_flag;
        logic receiver_disabled_flag;
        logic address_type_flag;
        logic missed_packet_flag;
        logic fifo_overrun_flag;
        logic alignment_error;
        logic crc_error;
        logic received_intact;
    } rfs_status_t;

    typedef struct packed {
        logic start;
        logic valid;
        logic [7:0] data;
        logic last;
        logic [2:0] dribble;
    } rfs_rx_t;

    typedef struct packed {
        logic valid;
        logic [7:0] status;
    } rfs_stat_wr_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_DATA = 2'b11,
        ST_DONE = 2'b10
    } rfs_state_t;

endpackage

// [hdl/rfs_tally.sv]
// one event tally counter, wraps at its width
// assumes inc is a one-cycle pulse, at most once per packet
module rfs_tally
    import rfs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic inc,
    output logic [TALLY_W-1:0] count
);

    // ************************************************************
    // counter
    // ************************************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            count <= '0;
        end else if (inc) begin
            count <= count + 1'b1;
        end
    end

endmodule

// [hdl/rfs_addr_filter.sv]
// destination address filter, purely combinational
// assumes the destination address and hash index are stable in the decision cycle
module rfs_addr_filter
    import rfs_pkg::*;
(
    input wire logic [47:0] dest_addr,
    input wire logic [47:0] station_addr,
    input wire logic [63:0] hash_filter,
    input wire logic [5:0] hash_idx,
    input wire rfs_cfg_t cfg,
    output logic hit,
    output logic group
);

    logic [5:0] byte_eq;
    logic bcast;
    logic mcast_ok;
    logic phys_ok;

    // ************************************************************
    // comparisons
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_byte
            assign byte_eq[g] = dest_addr[8*g +: 8] == station_addr[8*g +: 8];
        end
    endgenerate

    assign group = dest_addr[0];
    assign bcast = &dest_addr;
    assign phys_ok = !group && (cfg.promiscuous_physical || &byte_eq);
    assign mcast_ok = group && !bcast && cfg.accept_multicast && hash_filter[hash_idx];
    // group frames only pass through one of the two enables
    assign hit = phys_ok || mcast_ok || (bcast && cfg.accept_broadcast);

endmodule

// [hdl/rfs_top.sv]
// receive filter, receive status, tallies and transmit page start
// assumes decoder bytes and register strobes are synchronous to clk_sys
//
// Design decision made here: the strobed register port.
module rfs_top
    import rfs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire rfs_rx_t rx,
    input wire logic fifo_overflow,
    input wire logic buffer_full,
    input wire logic carrier_sense,
    input wire logic collision,
    input wire logic [47:0] station_addr,
    input wire logic [63:0] hash_filter,
    input wire logic tx_start,
    output logic [15:0] tx_dma_addr,
    output rfs_stat_wr_t stat_wr,
    output logic pkt_done,
    output logic pkt_accept
);

    rfs_state_t state_q;
    rfs_cfg_t cfg_q;
    logic [7:0] tx_page_q;
    logic [7:0] rdata_q;
    logic [31:0] crc_q;
    logic [31:0] crc_d;
    logic [LEN_W-1:0] len_q;
    logic [47:0] da_q;
    logic [5:0] hash_q;
    logic [2:0] dribble_q;
    logic ovr_q;
    logic [5:0] stat_q;
    logic dis_q;
    logic deferring;
    logic hit;
    logic group;
    logic crc_bad;
    logic fae;
    logic len_ok;
    logic missed;
    logic accept;
    logic done;
    logic [TALLY_W-1:0] align_cnt;
    logic [TALLY_W-1:0] crc_cnt;
    logic [TALLY_W-1:0] miss_cnt;

    // ************************************************************
    // crc
    // ************************************************************
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    assign crc_d = crc_byte(crc_q, rx.data);

    // ************************************************************
    // register bus
    // ************************************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cfg_q <= RST_RX_CONFIG;
        end else if (reg_wr && reg_addr == OFS_RX_CONFIG) begin
            cfg_q <= reg_wdata;
        end
    end

    // software keeps bit 5 low except to enter monitor mode
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dis_q <= 1'b0;
        end else if (reg_wr && reg_addr == OFS_RX_CONFIG) begin
            dis_q <= reg_wdata[5];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tx_page_q <= RST_TX_PAGE_START;
        end else if (reg_wr && reg_addr == OFS_TX_PAGE_START) begin
            tx_page_q <= reg_wdata;
        end
    end

    // read data stand for exactly one cycle, zero elsewhere
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= RST_BYTE;
        end else if (!reg_rd) begin
            rdata_q <= RST_BYTE;
        end else if (reg_addr == OFS_RX_STATUS) begin
            rdata_q <= {deferring, dis_q, stat_q};
        end else if (reg_addr == OFS_ALIGN_TALLY) begin
            rdata_q <= align_cnt;
        end else if (reg_addr == OFS_CRC_TALLY) begin
            rdata_q <= crc_cnt;
        end else if (reg_addr == OFS_MISSED_TALLY) begin
            rdata_q <= miss_cnt;
        end else begin
            rdata_q <= RST_BYTE;
        end
    end

    assign reg_rdata = rdata_q;
    assign deferring = carrier_sense || collision;

    // ************************************************************
    // transmit page start
    // ************************************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tx_dma_addr <= '0;
        end else if (tx_start) begin
            tx_dma_addr <= {tx_page_q, 8'h00};
        end
    end

    // ************************************************************
    // frame sequencing
    // ************************************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (rx.start) begin
                        state_q <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    if (rx.last || fifo_overflow) begin
                        state_q <= ST_DONE;
                    end else if (rx.valid && len_q == LAST_DA_BYTE) begin
                        state_q <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (rx.last || fifo_overflow) begin
                        state_q <= ST_DONE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            crc_q <= CRC_INIT;
            len_q <= '0;
        end else if (state_q == ST_IDLE) begin
            crc_q <= CRC_INIT;
            len_q <= '0;
        end else if (state_q != ST_DONE && rx.valid) begin
            crc_q <= crc_d;
            // saturate so a giant frame never wraps into a runt
            len_q <= (&len_q) ? len_q : len_q + 1'b1;
        end
    end

    // destination bytes arrive low byte first
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            da_q <= '0;
        end else if (state_q == ST_ADDR && rx.valid) begin
            da_q[8*len_q[2:0] +: 8] <= rx.data;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            hash_q <= '0;
        end else if (state_q == ST_ADDR && rx.valid && len_q == LAST_DA_BYTE) begin
            hash_q <= crc_d[31:26];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dribble_q <= '0;
        end else if (rx.last && state_q != ST_IDLE) begin
            dribble_q <= rx.dribble;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ovr_q <= 1'b0;
        end else if (state_q == ST_IDLE) begin
            ovr_q <= 1'b0;
        end else if (fifo_overflow && state_q != ST_DONE) begin
            ovr_q <= 1'b1;
        end
    end

    // ************************************************************
    // packet decision
    // ************************************************************
    rfs_addr_filter u_filter (
        .dest_addr(da_q),
        .station_addr(station_addr),
        .hash_filter(hash_filter),
        .hash_idx(hash_q),
        .cfg(cfg_q),
        .hit(hit),
        .group(group)
    );

    assign done = state_q == ST_DONE;
    assign crc_bad = !ovr_q && crc_q != CRC_RESIDUE;
    assign fae = crc_bad && dribble_q != 3'b000;
    assign len_ok = len_q >= MIN_FRAME || (cfg_q.accept_runts && len_q >= MIN_RUNT);
    assign missed = hit && len_ok && !ovr_q && (buffer_full || cfg_q.monitor_only);
    assign accept = hit && len_ok && !ovr_q && !missed && (!crc_bad || cfg_q.save_errored_packets);

    // status order from bit 0: intact, crc, alignment, overrun, missed, address type
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stat_q <= '0;
        end else if (state_q == ST_IDLE && rx.start) begin
            stat_q <= '0;
        end else if (done) begin
            stat_q[0] <= !crc_bad && !ovr_q && !missed;
            stat_q[1] <= crc_bad;
            stat_q[2] <= fae;
            stat_q[3] <= ovr_q;
            stat_q[4] <= missed;
            stat_q[5] <= hit && group;
        end
    end

    // memory copy carries the status as it stands after the decision
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stat_wr <= '0;
        end else begin
            stat_wr.valid <= done && accept;
            stat_wr.status <= done ? {deferring, dis_q, hit && group, missed, ovr_q, fae, crc_bad,
                                      !crc_bad && !ovr_q && !missed} : RST_BYTE;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pkt_done <= 1'b0;
            pkt_accept <= 1'b0;
        end else begin
            pkt_done <= done;
            pkt_accept <= done && accept;
        end
    end

    // ************************************************************
    // tallies
    // ************************************************************
    rfs_tally u_align_tally (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .inc(done && fae),
        .count(align_cnt)
    );

    rfs_tally u_crc_tally (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .inc(done && crc_bad),
        .count(crc_cnt)
    );

    rfs_tally u_missed_tally (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .inc(done && missed),
        .count(miss_cnt)
    );

    // ************************************************************
    // assertions
    // ************************************************************
    sequence s_frame_end;
        state_q == ST_DONE ##1 pkt_done;
    endsequence

    property p_err_reject;
        @(posedge clk_sys) disable iff (!arst_n)
        (done && crc_bad && !cfg_q.save_errored_packets) |-> ##1 !stat_wr.valid;
    endproperty
    a_err_reject: assert property (p_err_reject) else $error("errored packet stored");

    property p_runt;
        @(posedge clk_sys) disable iff (!arst_n)
        (done && len_q < MIN_RUNT) |-> ##1 !pkt_accept;
    endproperty
    a_runt: assert property (p_runt) else $error("short packet accepted");

    property p_bcast;
        @(posedge clk_sys) disable iff (!arst_n)
        (done && &da_q && !cfg_q.accept_broadcast) |-> ##1 !pkt_accept;
    endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast accepted while disabled");

    property p_phys;
        @(posedge clk_sys) disable iff (!arst_n)
        (done && !da_q[0] && !cfg_q.promiscuous_physical && da_q != station_addr) |-> ##1 !pkt_accept;
    endproperty
    a_phys: assert property (p_phys) else $error("foreign physical address accepted");

    property p_clear;
        @(posedge clk_sys) disable iff (!arst_n)
        (state_q == ST_IDLE && rx.start) |=> stat_q == 6'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("status not cleared at packet start");

    property p_intact;
        @(posedge clk_sys) disable iff (!arst_n)
        s_frame_end |-> stat_q[0] == (stat_q[4:1] == 4'h0);
    endproperty
    a_intact: assert property (p_intact) else $error("intact flag inconsistent");

    property p_pair;
        @(posedge clk_sys) disable iff (!arst_n)
        stat_q[2] |-> stat_q[1];
    endproperty
    a_pair: assert property (p_pair) else $error("alignment without crc flag");

    property p_overrun;
        @(posedge clk_sys) disable iff (!arst_n)
        (fifo_overflow && (state_q == ST_ADDR || state_q == ST_DATA)) |=> done ##1 (stat_q[3] && !pkt_accept);
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not reported");

    property p_crc_tally;
        @(posedge clk_sys) disable iff (!arst_n)
        (done && crc_bad) |=> crc_cnt == $past(crc_cnt) + 1'b1;
    endproperty
    a_crc_tally: assert property (p_crc_tally) else $error("crc tally not bumped");

    property p_tx_addr;
        @(posedge clk_sys) disable iff (!arst_n)
        tx_start |=> tx_dma_addr == {$past(tx_page_q), 8'h00};
    endproperty
    a_tx_addr: assert property (p_tx_addr) else $error("transmit address wrong");

    property p_defer;
        @(posedge clk_sys) disable iff (!arst_n)
        (reg_rd && reg_addr == OFS_RX_STATUS && collision) |=> reg_rdata[7];
    endproperty
    a_defer: assert property (p_defer) else $error("deferring flag missing");

endmodule

// [tb/rfs_dec_model.sv]
// decoder side model: hands received packet bytes to the filter
// assumes the bench calls send_pkt and leaves two idle cycles between packets
module rfs_dec_model
    import rfs_pkg::*;
(
    input wire logic clk_sys,
    output rfs_rx_t rx,
    output logic fifo_overflow
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // packet delivery
    // ****************************************
    initial begin
        rx = '0;
        fifo_overflow = 1'b0;
    end

    // gap adds idle cycles per byte to act as a slow decoder; ovf aborts at that byte
    task automatic send_pkt(input logic [7:0] pkt[$], input logic [2:0] drib, input int ovf, input int gap);
        @(posedge clk_sys);
        rx.start <= 1'b1;
        foreach (pkt[i]) begin
            @(posedge clk_sys);
            rx.start <= 1'b0;
            if (i == ovf) begin
                rx.valid <= 1'b0;
                fifo_overflow <= 1'b1;
                @(posedge clk_sys);
                fifo_overflow <= 1'b0;
                return;
            end
            rx.valid <= 1'b1;
            rx.data <= pkt[i];
            repeat (gap) begin
                @(posedge clk_sys);
                rx.valid <= 1'b0;
                rx.data <= ~pkt[i];
            end
        end
        @(posedge clk_sys);
        rx.valid <= 1'b0;
        rx.data <= ~rx.data;
        rx.last <= 1'b1;
        rx.dribble <= drib;
        @(posedge clk_sys);
        rx.last <= 1'b0;
        rx.dribble <= 3'h0;
    endtask
endmodule

// [tb/test_rfs_top.sv]
// self-checking bench for the receive filter and status block
// assumes a 40 MHz clock and the decoder model beside the design
module test_rfs_top;
    import rfs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // stimulus and monitors
    // ****************************************
    localparam logic [47:0] STA = 48'h554433221100;
    localparam logic [47:0] BC = 48'hFFFFFFFFFFFF;
    localparam logic [47:0] MC = 48'h000000000003;
    logic clk_sys, arst_n, reg_wr, reg_rd, fifo_overflow, buffer_full, carrier_sense, collision, tx_start;
    logic [ADDR_W-1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, sw_val, d;
    logic [63:0] hash_filter;
    logic [15:0] tx_dma_addr;
    rfs_rx_t rx;
    rfs_stat_wr_t stat_wr;
    logic pkt_done, pkt_accept, done_seen, acc_seen, sw_seen;
    logic [7:0] pkt_q[$];
    int n_errors = 0;
    int num_checks = 0;

    rfs_top u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx(rx), .fifo_overflow(fifo_overflow),
        .buffer_full(buffer_full), .carrier_sense(carrier_sense), .collision(collision),
        .station_addr(STA), .hash_filter(hash_filter), .tx_start(tx_start), .tx_dma_addr(tx_dma_addr),
        .stat_wr(stat_wr), .pkt_done(pkt_done), .pkt_accept(pkt_accept));
    rfs_dec_model u_dec (.clk_sys(clk_sys), .rx(rx), .fifo_overflow(fifo_overflow));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (pkt_done === 1'b1) begin
            done_seen <= 1'b1;
            acc_seen <= pkt_accept;
        end
        if (stat_wr.valid === 1'b1) begin
            sw_seen <= 1'b1;
            sw_val <= stat_wr.status;
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        v = reg_rdata;
        @(posedge clk_sys);
    endtask

    function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [7:0] b);
        c = c ^ {24'h000000, b};
        for (int k = 0; k < 8; k++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    function automatic logic [5:0] hash_of(input logic [47:0] da);
        logic [31:0] c;
        c = CRC_INIT;
        for (int i = 0; i < 6; i++) begin
            c = crc_upd(c, da[8*i+:8]);
        end
        return c[31:26];
    endfunction

    // len counts every byte including the four check bytes; bad spoils the last check byte
    task automatic run_pkt(input logic [47:0] da, input int len, input logic bad, input logic [2:0] drib,
            input int ovf, input int gap, input logic exp_acc, input logic [7:0] exp_st);
        logic [31:0] c;
        int w;
        pkt_q.delete();
        c = CRC_INIT;
        for (int i = 0; i < len - 4; i++) begin
            pkt_q.push_back(i < 6 ? da[8*i+:8] : 8'(i));
            c = crc_upd(c, pkt_q[i]);
        end
        c = ~c;
        for (int k = 0; k < 4; k++) begin
            pkt_q.push_back(c[8*k+:8] ^ {7'h00, bad && k == 3});
        end
        done_seen = 1'b0;
        sw_seen = 1'b0;
        u_dec.send_pkt(pkt_q, drib, ovf, gap);
        w = 0;
        while (done_seen !== 1'b1 && w < 20) begin
            @(posedge clk_sys);
            w++;
        end
        @(posedge clk_sys);
        check(16'(done_seen), 16'h1);
        check(16'(acc_seen), 16'(exp_acc));
        check(16'(sw_seen), 16'(exp_acc));
        if (exp_acc) check(16'(sw_val), 16'(exp_st));
        reg_read(OFS_RX_STATUS, d);
        if (exp_st !== 8'hFF) check(16'(d), 16'(exp_st));
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_filter();
        reg_write(OFS_RX_CONFIG, 8'h00);
        run_pkt(STA, 64, 0, 0, -1, 0, 1, 8'h01);
        run_pkt(48'h5544332211AA, 64, 0, 0, -1, 0, 0, 8'hFF);
        run_pkt(BC, 64, 0, 0, -1, 0, 0, 8'hFF);
        reg_write(OFS_RX_CONFIG, 8'h10);
        run_pkt(48'h5544332211AA, 64, 0, 0, -1, 0, 1, 8'h01);
        reg_write(OFS_RX_CONFIG, 8'h04);
        run_pkt(BC, 64, 0, 0, -1, 2, 1, 8'h21);
        hash_filter <= 64'h1 << hash_of(MC);
        run_pkt(MC, 64, 0, 0, -1, 0, 0, 8'hFF);
        reg_write(OFS_RX_CONFIG, 8'h0C);
        run_pkt(MC, 64, 0, 0, -1, 0, 1, 8'h21);
        run_pkt(STA, 64, 0, 0, -1, 0, 1, 8'h01);
        hash_filter <= ~(64'h1 << hash_of(MC));
        run_pkt(MC, 64, 0, 0, -1, 0, 0, 8'hFF);
        hash_filter <= '1;
        reg_write(OFS_RX_CONFIG, 8'h1C);
        run_pkt(48'h0000000000A5, 64, 0, 0, -1, 0, 1, 8'h21);
        $display("test filter done");
    endtask

    task automatic t_errors();
        reg_write(OFS_RX_CONFIG, 8'h00);
        run_pkt(STA, 64, 1, 0, -1, 0, 0, 8'h02);
        reg_write(OFS_RX_CONFIG, 8'h01);
        run_pkt(STA, 64, 1, 0, -1, 0, 1, 8'h02);
        reg_read(OFS_CRC_TALLY, d);
        check(16'(d), 16'h2);
        run_pkt(STA, 64, 1, 3, -1, 0, 1, 8'h06);
        reg_read(OFS_ALIGN_TALLY, d);
        check(16'(d), 16'h1);
        run_pkt(STA, 64, 0, 5, -1, 0, 1, 8'h01);
        run_pkt(STA, 64, 0, 0, 20, 0, 0, 8'h08);
        $display("test errors done");
    endtask

    task automatic t_runt();
        reg_write(OFS_RX_CONFIG, 8'h00);
        run_pkt(STA, 63, 0, 0, -1, 0, 0, 8'hFF);
        reg_write(OFS_RX_CONFIG, 8'h12);
        run_pkt(STA, 63, 0, 0, -1, 0, 1, 8'h01);
        run_pkt(STA, 8, 0, 0, -1, 0, 1, 8'h01);
        reg_write(OFS_RX_CONFIG, 8'h13);
        run_pkt(STA, 7, 0, 0, -1, 0, 0, 8'hFF);
        $display("test runt done");
    endtask

    task automatic t_missed();
        reg_write(OFS_RX_CONFIG, 8'h00);
        buffer_full <= 1'b1;
        run_pkt(STA, 64, 0, 0, -1, 0, 0, 8'h10);
        buffer_full <= 1'b0;
        reg_write(OFS_RX_CONFIG, 8'h20);
        run_pkt(STA, 64, 0, 0, -1, 0, 0, 8'h50);
        reg_read(OFS_MISSED_TALLY, d);
        check(16'(d), 16'h2);
        reg_write(OFS_RX_CONFIG, 8'h00);
        run_pkt(STA, 64, 0, 0, -1, 0, 1, 8'h01);
        $display("test missed done");
    endtask

    task automatic t_regs();
        logic [7:0] pg[2] = '{8'hA5, 8'h3C};
        carrier_sense <= 1'b1;
        reg_read(OFS_RX_STATUS, d);
        check(16'(d[7]), 16'h1);
        carrier_sense <= 1'b0;
        collision <= 1'b1;
        reg_read(OFS_RX_STATUS, d);
        check(16'(d[7]), 16'h1);
        collision <= 1'b0;
        reg_read(OFS_RX_STATUS, d);
        check(16'(d[7]), 16'h0);
        foreach (pg[i]) begin
            reg_write(OFS_TX_PAGE_START, pg[i]);
            @(posedge clk_sys);
            tx_start <= 1'b1;
            @(posedge clk_sys);
            tx_start <= 1'b0;
            @(negedge clk_sys);
            check(tx_dma_addr, {pg[i], 8'h00});
        end
        reg_read(4'h1, d);
        check(16'(d), 16'h0);
        $display("test registers done");
    endtask

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        arst_n = 1'b0;
        {reg_wr, reg_rd, buffer_full, carrier_sense, collision, tx_start} = '0;
        reg_addr = '0;
        reg_wdata = '0;
        hash_filter = '0;
        {done_seen, acc_seen, sw_seen, sw_val} = '0;
        repeat (5) @(posedge clk_sys);
        arst_n <= 1'b1;
        reg_read(OFS_RX_STATUS, d);
        check(16'(d), 16'h0);
        check(tx_dma_addr, 16'h0000);
        t_filter();
        t_errors();
        t_runt();
        t_missed();
        t_regs();
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        give_verdict();
    end
endmodule
